// File: rxb_eng_model.sv
`timescale 1ns/1ns
// ******************************************************************
// Engine payload source.
// ******************************************************************
module rxb_eng_model (
   input  wire logic        sys_clk,
   input  wire logic        pay_req,
   input  wire logic        pay_chan,
   input  wire logic [6:0]  pay_idx,
   output logic      [15:0] eng_pay_word
);
   logic [15:0] idle_word_q = 16'h0000;

   // Outside an answer the word flips each cycle, so a misplaced sample fails.
   always @(posedge sys_clk) begin
      idle_word_q <= ~idle_word_q;
   end
   // The copy logic stores the word in the cycle of its own request.
   always_comb begin
      eng_pay_word = idle_word_q;
      if (pay_req) begin
         eng_pay_word = {pay_chan ? 4'hb : 4'ha, 5'h00, pay_idx};
      end
   end
endmodule // rxb_eng_model

// File: rxb_match.sv
`timescale 1ns/1ns
module rxb_match import rxb_pkg::*; (
   input  wire logic [31:0] cfg,
   input  wire logic [31:0] cyc,
   input  wire logic [10:0] slot_id,
   input  wire logic [5:0]  cycle_num,
   input  wire logic        dyn_seg,
   output logic             hit_a,
   output logic             hit_b
);
   logic [6:0] rep;
   logic [6:0] rem;
   logic [1:0] chan;
   logic       base;

   always_comb begin
      rep  = cyc[CYC_REP_LSB +: 7];
      // Repetition is never zero: writes of illegal values are ignored.
      rem  = 7'({1'b0, cycle_num} % rep);
      chan = cfg[CFG_CHAN_LSB +: 2];
      base = (cfg[CFG_SLOT_LSB +: 11] == slot_id) &&
             (rem == {1'b0, cyc[CYC_OFS_LSB +: 6]});
      // A two-channel buffer is a static-segment feature only.
      hit_a = base && chan[0] && !(dyn_seg && chan == CH_AB);
      hit_b = base && chan[1] && !(dyn_seg && chan == CH_AB);
   end

endmodule // rxb_match

// File: rxb_pkg.sv
package rxb_pkg;

   // ********************************************************
   // Register map inside one buffer window
   // ********************************************************
   localparam int         BUF_SHIFT = 10;
   localparam logic [9:0] OFS_CFG   = 10'h000;
   localparam logic [9:0] OFS_CYC   = 10'h004;
   localparam logic [9:0] OFS_STAT  = 10'h008;
   localparam logic [9:0] OFS_HDR   = 10'h00c;
   localparam logic [9:0] OFS_FLG   = 10'h010;
   localparam logic [9:0] OFS_PAY   = 10'h080;

   // ********************************************************
   // Field positions
   // ********************************************************
   localparam int CFG_SLOT_LSB = 0;
   localparam int CFG_CHAN_LSB = 11;
   localparam int CFG_LOCK_BIT = 15;
   localparam int CFG_CAP_LSB  = 16;
   localparam int CYC_REP_LSB  = 0;
   localparam int CYC_OFS_LSB  = 8;
   localparam int STAT_B_LSB   = 8;
   localparam int STAT_UPD     = 5;
   localparam int ST_VF        = 0;
   localparam int ST_NIND      = 4;
   localparam int HDR_LEN_LSB  = 16;
   localparam int HDR_CYC_LSB  = 24;
   localparam int FLG_CHAN_BIT = 5;
   localparam int FLG_PV_BIT   = 6;
   localparam int FLG_EVER_BIT = 7;
   localparam int FLG_CRC_LSB  = 16;

   // ********************************************************
   // Channel sets and reset values
   // ********************************************************
   localparam logic [1:0]  CH_A    = 2'h1;
   localparam logic [1:0]  CH_B    = 2'h2;
   localparam logic [1:0]  CH_AB   = 2'h3;
   localparam logic [31:0] CFG_RST = 32'h0001_0000;
   localparam logic [31:0] CYC_RST = 32'h0000_0001;

   typedef enum logic [1:0] {RXB_IDLE, RXB_NEXT, RXB_COPY} rxb_state_t;

   function automatic logic rxb_rep_legal(input logic [6:0] r);
      case (r)
         7'h01, 7'h02, 7'h04, 7'h05, 7'h08, 7'h0a,
         7'h10, 7'h14, 7'h20, 7'h28, 7'h32, 7'h40: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

endpackage

// File: rxb_properties.sv
`timescale 1ns/1ns
// ******************************************************************
// Checker on the top ports.
// ******************************************************************
module rxb_props #(
   parameter int MAX_WORDS = 16
) (
   input wire logic        sys_clk,
   input wire logic        sys_rst,
   input wire logic        reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic        reg_rd_fail,
   input wire logic        eng_slot_end,
   input wire logic        eng_tx_claim_a,
   input wire logic        eng_tx_claim_b,
   input wire logic [4:0]  eng_a_status,
   input wire logic [4:0]  eng_b_status,
   input wire logic        pay_req,
   input wire logic        pay_chan,
   input wire logic [6:0]  pay_idx,
   input wire logic        rx_busy
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   sequence s_take;
      eng_slot_end && !rx_busy;
   endsequence
   // Six quiet cycles outlast a job that copies nothing.
   sequence s_quiet;
      !pay_req [*6];
   endsequence
   AST_RD_ONLY: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
      else $error("read data outside a read answer");
   AST_FAIL: assert property (reg_rd_fail |-> $past(reg_rd) && reg_rdata == 32'h0)
      else $error("read failure without read or with data");
   AST_BUSY: assert property (s_take |=> rx_busy)
      else $error("slot end not taken");
   AST_IDLE: assert property (!rx_busy && !eng_slot_end |=> !rx_busy)
      else $error("busy without slot end");
   AST_REQ_BUSY: assert property (pay_req |-> rx_busy)
      else $error("word request outside a copy");
   AST_FIRST: assert property ($rose(pay_req) |-> pay_idx == 7'h00)
      else $error("copy does not start at word zero");
   AST_STEP: assert property (pay_req && $past(pay_req) |->
      pay_idx == $past(pay_idx) + 7'h01 && pay_chan == $past(pay_chan))
      else $error("word requests not consecutive");
   AST_CAP: assert property (pay_req |-> int'(pay_idx) < MAX_WORDS)
      else $error("word request beyond capacity");
   AST_TX: assert property (s_take and eng_tx_claim_a && eng_tx_claim_b
      |=> s_quiet)
      else $error("copy in a transmit slot");
   AST_NULL: assert property (s_take and !eng_a_status[4] && !eng_b_status[4]
      |=> s_quiet)
      else $error("copy without a non-null frame");
   AST_DONE: assert property ($rose(rx_busy) |-> ##[1:60] !rx_busy)
      else $error("copy does not finish");
endmodule // rxb_props

// File: rxb_top.sv
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/1ns
module rxb_top import rxb_pkg::*; #(
   parameter int NUM_BUF   = 4,
   parameter int MAX_WORDS = 16
) (
   input  wire logic                               sys_clk,
   input  wire logic                               sys_rst,
   input  wire logic [BUF_SHIFT+$clog2(NUM_BUF)-1:0] reg_addr,
   input  wire logic [31:0]                        reg_wdata,
   input  wire logic                               reg_wr,
   input  wire logic                               reg_rd,
   output logic      [31:0]                        reg_rdata,
   output logic                                    reg_rd_fail,
   input  wire logic                               eng_slot_end,
   input  wire logic [10:0]                        eng_slot_id,
   input  wire logic [5:0]                         current_cycle_number,
   input  wire logic                               eng_dynamic,
   input  wire logic                               eng_tx_claim_a,
   input  wire logic                               eng_tx_claim_b,
   input  wire logic [4:0]                         eng_a_status,
   input  wire logic [4:0]                         eng_b_status,
   input  wire logic [10:0]                        eng_a_frame_id,
   input  wire logic [10:0]                        eng_b_frame_id,
   input  wire logic [6:0]                         eng_a_length,
   input  wire logic [6:0]                         eng_b_length,
   input  wire logic [5:0]                         eng_a_cycle,
   input  wire logic [5:0]                         eng_b_cycle,
   input  wire logic [10:0]                        eng_a_hdr_crc,
   input  wire logic [10:0]                        eng_b_hdr_crc,
   input  wire logic [4:0]                         eng_a_flags,
   input  wire logic [4:0]                         eng_b_flags,
   input  wire logic [15:0]                        eng_pay_word,
   output logic                                    pay_req,
   output logic                                    pay_chan,
   output logic      [6:0]                         pay_idx,
   output logic                                    rx_busy
);
   localparam int BW = $clog2(NUM_BUF);
   localparam int AW = BUF_SHIFT + BW;

   // ********************************************************
   // Storage
   // ********************************************************
   logic [31:0] cfg_q [NUM_BUF];
   logic [31:0] cfg_d [NUM_BUF];
   logic [31:0] cyc_q [NUM_BUF];
   logic [31:0] cyc_d [NUM_BUF];
   logic [15:0] stat_q [NUM_BUF];
   logic [15:0] stat_d [NUM_BUF];
   logic [31:0] hdr_q [NUM_BUF];
   logic [31:0] hdr_d [NUM_BUF];
   logic [31:0] flg_q [NUM_BUF];
   logic [31:0] flg_d [NUM_BUF];
   logic [15:0] pay_mem_q [NUM_BUF*MAX_WORDS];

   rxb_state_t  state_q;
   rxb_state_t  state_d;
   logic [1:0]  jv_q;
   logic [1:0]  jv_d;
   logic [1:0]  jc_q;
   logic [1:0]  jc_d;
   logic [BW-1:0] jb_q [2];
   logic [BW-1:0] jb_d [2];
   logic [BW-1:0] cur_buf_q;
   logic [BW-1:0] cur_buf_d;
   logic        cur_ch_q;
   logic        cur_ch_d;
   logic [6:0]  cnt_q;
   logic [6:0]  cnt_d;
   logic [6:0]  words_q;
   logic [6:0]  words_d;
   logic        req_q;
   logic        req_d;
   logic [6:0]  idx_q;
   logic [6:0]  idx_d;
   logic        busy_q;
   logic        busy_d;
   logic [31:0] rdata_q;
   logic [31:0] rdata_d;
   logic        fail_q;
   logic        fail_d;
   logic        commit;

   // ********************************************************
   // Buffer matching and selection
   // ********************************************************
   logic [NUM_BUF-1:0] hit_a;
   logic [NUM_BUF-1:0] hit_b;
   logic [BW-1:0]      act_a;
   logic [BW-1:0]      act_b;
   logic               a_en;
   logic               b_en;
   logic               a_frame;
   logic               b_frame;
   logic               lock_a;
   logic               lock_b;
   logic [1:0]         w_v;
   logic [1:0]         w_lock;
   logic [1:0]         w_ch;
   logic [BW-1:0]      w_buf [2];

   for (genvar g = 0; g < NUM_BUF; g++) begin : g_match
      rxb_match u_match (
         .cfg       (cfg_q[g]),
         .cyc       (cyc_q[g]),
         .slot_id   (eng_slot_id),
         .cycle_num (current_cycle_number),
         .dyn_seg   (eng_dynamic),
         .hit_a     (hit_a[g]),
         .hit_b     (hit_b[g])
      );
   end

   always_comb begin
      act_a = '0;
      act_b = '0;
      a_en  = 1'b0;
      b_en  = 1'b0;
      // Descending scan so the lowest matching index is kept.
      for (int i = NUM_BUF - 1; i >= 0; i--) begin
         if (hit_a[i]) begin
            act_a = BW'(i);
            a_en  = 1'b1;
         end
         if (hit_b[i]) begin
            act_b = BW'(i);
            b_en  = 1'b1;
         end
      end
      a_en    = a_en && !eng_tx_claim_a;
      b_en    = b_en && !eng_tx_claim_b;
      a_frame = eng_a_status[ST_VF] && eng_a_status[ST_NIND];
      b_frame = eng_b_status[ST_VF] && eng_b_status[ST_NIND];
      lock_a  = cfg_q[act_a][CFG_LOCK_BIT];
      lock_b  = cfg_q[act_b][CFG_LOCK_BIT];
      w_buf[0] = act_a;
      w_buf[1] = act_b;
      w_ch     = 2'b10;
      w_lock   = {lock_b, lock_a};
      if (a_en && b_en && act_a == act_b) begin
         // One two-channel buffer: pick a single frame for it.
         w_v[1] = 1'b0;
         if (a_frame) begin
            w_v[0] = 1'b1;
         end else if (b_frame) begin
            w_v[0] = 1'b1;
            w_ch[0] = 1'b1;
         end else begin
            w_v[0] = 1'b0;
         end
      end else begin
         w_v = {b_en && b_frame, a_en && a_frame};
      end
   end

   // ********************************************************
   // Copy engine
   // ********************************************************
   logic       nk;
   logic [6:0] nlen;
   logic [6:0] ncap;

   always_comb begin
      state_d   = state_q;
      jv_d      = jv_q;
      jc_d      = jc_q;
      jb_d      = jb_q;
      cur_buf_d = cur_buf_q;
      cur_ch_d  = cur_ch_q;
      cnt_d     = cnt_q;
      words_d   = words_q;
      req_d     = 1'b0;
      idx_d     = idx_q;
      commit    = 1'b0;
      nk        = !jv_q[0];
      nlen      = jc_q[nk] ? eng_b_length : eng_a_length;
      ncap      = cfg_q[jb_q[nk]][CFG_CAP_LSB +: 7];
      case (state_q)
         RXB_IDLE: begin
            if (eng_slot_end) begin
               // A locked buffer is skipped whole, never half written.
               jv_d    = w_v & ~w_lock;
               jc_d    = w_ch;
               jb_d    = w_buf;
               state_d = RXB_NEXT;
            end
         end
         RXB_NEXT: begin
            if (|jv_q) begin
               cur_buf_d = jb_q[nk];
               cur_ch_d  = jc_q[nk];
               jv_d[nk]  = 1'b0;
               words_d   = (nlen < ncap) ? nlen : ncap;
               cnt_d     = 7'h00;
               state_d   = RXB_COPY;
            end else begin
               state_d = RXB_IDLE;
            end
         end
         RXB_COPY: begin
            if (cnt_q < words_q) begin
               req_d = 1'b1;
               idx_d = cnt_q;
               cnt_d = cnt_q + 7'h01;
            end else if (!req_q) begin
               commit  = 1'b1;
               state_d = RXB_NEXT;
            end
         end
         default: state_d = RXB_IDLE;
      endcase
      busy_d = (state_d != RXB_IDLE);
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_q   <= RXB_IDLE;
         jv_q      <= 2'h0;
         jc_q      <= 2'h0;
         jb_q[0]   <= '0;
         jb_q[1]   <= '0;
         cur_buf_q <= '0;
         cur_ch_q  <= 1'b0;
         cnt_q     <= 7'h00;
         words_q   <= 7'h00;
         req_q     <= 1'b0;
         idx_q     <= 7'h00;
         busy_q    <= 1'b0;
      end else begin
         state_q   <= state_d;
         jv_q      <= jv_d;
         jc_q      <= jc_d;
         jb_q      <= jb_d;
         cur_buf_q <= cur_buf_d;
         cur_ch_q  <= cur_ch_d;
         cnt_q     <= cnt_d;
         words_q   <= words_d;
         req_q     <= req_d;
         idx_q     <= idx_d;
         busy_q    <= busy_d;
      end
   end

   // Payload words land while the buffer is marked busy to the host.
   always_ff @(posedge sys_clk) begin
      if (req_q) begin
         pay_mem_q[int'(cur_buf_q) * MAX_WORDS + int'(idx_q)] <=
            eng_pay_word;
      end
   end

   // ********************************************************
   // Register file
   // ********************************************************
   logic [BW-1:0] wb;
   logic [9:0]    wofs;
   logic [6:0]    wcap;
   logic [6:0]    wrep;
   logic [5:0]    woff;

   always_comb begin
      cfg_d  = cfg_q;
      cyc_d  = cyc_q;
      stat_d = stat_q;
      hdr_d  = hdr_q;
      flg_d  = flg_q;
      wb     = reg_addr[AW-1:BUF_SHIFT];
      wofs   = reg_addr[BUF_SHIFT-1:0];
      wcap   = reg_wdata[CFG_CAP_LSB +: 7];
      wrep   = reg_wdata[CYC_REP_LSB +: 7];
      woff   = reg_wdata[CYC_OFS_LSB +: 6];
      if (wcap == 7'h00) begin
         wcap = 7'h01;
      end else if (wcap > 7'(MAX_WORDS)) begin
         wcap = 7'(MAX_WORDS);
      end
      if (reg_wr && int'(wb) < NUM_BUF) begin
         if (wofs == OFS_CFG) begin
            cfg_d[wb] = {9'h000, wcap, reg_wdata[15:0]};
            flg_d[wb][FLG_PV_BIT]   = 1'b0;
            flg_d[wb][FLG_EVER_BIT] = 1'b0;
         end else if (wofs == OFS_CYC) begin
            if (rxb_rep_legal(wrep) && {1'b0, woff} < wrep) begin
               cyc_d[wb] = {18'h00000, woff, 1'b0, wrep};
            end
         end else if (wofs == OFS_STAT) begin
            stat_d[wb][STAT_UPD] = stat_q[wb][STAT_UPD] &
                                   !reg_wdata[STAT_UPD];
            stat_d[wb][STAT_B_LSB + STAT_UPD] =
               stat_q[wb][STAT_B_LSB + STAT_UPD] &
               !reg_wdata[STAT_B_LSB + STAT_UPD];
         end
      end
      // Engine updates follow the host so a set beats a same-cycle clear.
      if (state_q == RXB_IDLE && eng_slot_end) begin
         if (a_en) begin
            if (lock_a) begin
               flg_d[act_a][FLG_PV_BIT] = 1'b0;
            end else begin
               stat_d[act_a][5:0] = {1'b1, eng_a_status};
            end
         end
         if (b_en) begin
            if (lock_b) begin
               flg_d[act_b][FLG_PV_BIT] = 1'b0;
            end else begin
               stat_d[act_b][STAT_B_LSB +: 6] = {1'b1, eng_b_status};
            end
         end
      end
      if (commit) begin
         // The stored length stays as received so truncation is visible.
         hdr_d[cur_buf_q] = cur_ch_q ?
            {2'h0, eng_b_cycle, 1'b0, eng_b_length, 5'h00, eng_b_frame_id} :
            {2'h0, eng_a_cycle, 1'b0, eng_a_length, 5'h00, eng_a_frame_id};
         flg_d[cur_buf_q] = {5'h00,
            cur_ch_q ? eng_b_hdr_crc : eng_a_hdr_crc, 8'h00,
            2'h3, cur_ch_q,
            cur_ch_q ? eng_b_flags : eng_a_flags};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_BUF; i++) begin
            cfg_q[i]  <= CFG_RST;
            cyc_q[i]  <= CYC_RST;
            stat_q[i] <= 16'h0000;
            hdr_q[i]  <= 32'h0000_0000;
            flg_q[i]  <= 32'h0000_0000;
         end
      end else begin
         cfg_q  <= cfg_d;
         cyc_q  <= cyc_d;
         stat_q <= stat_d;
         hdr_q  <= hdr_d;
         flg_q  <= flg_d;
      end
   end

   // ********************************************************
   // Host read port
   // ********************************************************
   logic [BW-1:0] rb;
   logic [9:0]    rofs;
   logic [9:0]    pofs;
   logic          rbusy;

   always_comb begin
      rdata_d = 32'h0000_0000;
      fail_d  = 1'b0;
      rb      = reg_addr[AW-1:BUF_SHIFT];
      rofs    = reg_addr[BUF_SHIFT-1:0];
      pofs    = rofs - OFS_PAY;
      rbusy   = (state_q == RXB_COPY) && (cur_buf_q == rb);
      if (reg_rd && int'(rb) < NUM_BUF) begin
         if (rofs == OFS_CFG) begin
            rdata_d = cfg_q[rb];
         end else if (rofs == OFS_CYC) begin
            rdata_d = cyc_q[rb];
         end else if (rofs == OFS_STAT) begin
            rdata_d = {16'h0000, stat_q[rb]};
         end else if (rofs == OFS_HDR || rofs == OFS_FLG ||
                      (rofs >= OFS_PAY && pofs[1:0] == 2'h0 &&
                       int'(pofs[9:2]) < MAX_WORDS)) begin
            // A half-copied frame is never shown; the host retries.
            if (rbusy) begin
               fail_d = 1'b1;
            end else if (rofs == OFS_HDR) begin
               rdata_d = hdr_q[rb];
            end else if (rofs == OFS_FLG) begin
               rdata_d = flg_q[rb];
            end else begin
               rdata_d = {16'h0000,
                  pay_mem_q[int'(rb) * MAX_WORDS + int'(pofs[9:2])]};
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         rdata_q <= 32'h0000_0000;
         fail_q  <= 1'b0;
      end else begin
         rdata_q <= rdata_d;
         fail_q  <= fail_d;
      end
   end

   assign reg_rdata   = rdata_q;
   assign reg_rd_fail = fail_q;
   assign pay_req     = req_q;
   assign pay_chan    = cur_ch_q;
   assign pay_idx     = idx_q;
   assign rx_busy     = busy_q;

endmodule // rxb_top

// File: tb_top.sv
`timescale 1ns/1ns
// ******************************************************************
// Testbench.
// ******************************************************************
module tb_top;
   import rxb_pkg::*;
   localparam logic [4:0] VN = 5'h11;
   localparam logic [4:0] NL = 5'h01;
   localparam logic [4:0] NO = 5'h00;
   logic        sys_clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0;
   logic        reg_rd = 1'b0, eng_slot_end = 1'b0, eng_dynamic = 1'b0;
   logic        eng_tx_claim_a = 1'b0, eng_tx_claim_b = 1'b0;
   logic [11:0] reg_addr = 12'h000;
   logic [31:0] reg_wdata = 32'h0, reg_rdata;
   logic [10:0] eng_slot_id = 11'h000;
   logic [5:0]  current_cycle_number = 6'h00;
   logic [4:0]  eng_a_status = 5'h00, eng_b_status = 5'h00;
   logic [4:0]  eng_b_flags = 5'h0a;
   logic [6:0]  eng_a_length = 7'h00, eng_b_length = 7'h00, pay_idx;
   logic [15:0] eng_pay_word;
   logic        reg_rd_fail, pay_req, pay_chan, rx_busy;
   int          n_fail = 0, total_checks = 0, cycles = 0;

   rxb_top #(.NUM_BUF(4), .MAX_WORDS(8)) u_rxb_top (
      .sys_clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .reg_rd_fail, .eng_slot_end, .eng_slot_id,
      .current_cycle_number, .eng_dynamic, .eng_tx_claim_a,
      .eng_tx_claim_b, .eng_a_status, .eng_b_status,
      .eng_a_frame_id(eng_slot_id), .eng_b_frame_id(eng_slot_id),
      .eng_a_length, .eng_b_length, .eng_a_cycle(current_cycle_number),
      .eng_b_cycle(current_cycle_number), .eng_a_hdr_crc(11'h0aa),
      .eng_b_hdr_crc(11'h155), .eng_a_flags(5'h06), .eng_b_flags,
      .eng_pay_word, .pay_req, .pay_chan, .pay_idx, .rx_busy);
   rxb_eng_model u_rxb_eng_model (.sys_clk, .pay_req, .pay_chan, .pay_idx,
      .eng_pay_word);

   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         n_fail++;
         wrap_up();
      end
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [1:0] b, input logic [9:0] o,
                     input logic [31:0] d);
      @(posedge sys_clk);
      reg_addr <= {b, o};
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [1:0] b, input logic [9:0] o,
                     input logic [31:0] e, input logic f = 1'b0);
      @(posedge sys_clk);
      reg_addr <= {b, o};
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      chk({31'h0, reg_rd_fail}, {31'h0, f});
      chk(reg_rdata, e);
   endtask
   // The slot inputs stay put until the next call, past the end of copy.
   task automatic slot(input logic [10:0] id, input logic [5:0] cy,
                       input logic [2:0] md, input logic [4:0] sa,
                       input logic [4:0] sb, input logic [6:0] la,
                       input logic [6:0] lb);
      @(posedge sys_clk);
      eng_slot_id <= id;
      current_cycle_number <= cy;
      {eng_dynamic, eng_tx_claim_a, eng_tx_claim_b} <= md;
      {eng_a_status, eng_b_status, eng_a_length, eng_b_length} <=
         {sa, sb, la, lb};
      eng_slot_end <= 1'b1;
      @(posedge sys_clk);
      eng_slot_end <= 1'b0;
   endtask
   task automatic idle;
      repeat (2) @(posedge sys_clk);
      for (int i = 0; i < 100 && rx_busy !== 1'b0; i++) @(posedge sys_clk);
      chk({31'h0, rx_busy}, 32'h0);
   endtask

   initial begin
      repeat (20) @(posedge sys_clk);
      sys_rst <= 1'b0;
      rd(2'h0, OFS_CFG, CFG_RST);
      rd(2'h0, OFS_CYC, CYC_RST);
      rd(2'h0, 10'h020, 32'h0);
      wr(2'h0, OFS_CFG, 32'h0008_1805);
      slot(11'h5, 6'h0, 3'h0, VN, VN, 7'h3, 7'h3);
      idle;
      rd(2'h0, OFS_FLG, 32'h00aa_00c6);
      rd(2'h0, OFS_HDR, 32'h0003_0005);
      rd(2'h0, OFS_PAY + 10'h008, 32'h0000_a002);
      slot(11'h5, 6'h1, 3'h0, NL, VN, 7'h3, 7'h2);
      idle;
      rd(2'h0, OFS_FLG, 32'h0155_00ea);
      rd(2'h0, OFS_PAY + 10'h004, 32'h0000_b001);
      slot(11'h5, 6'h2, 3'h0, VN, NO, 7'h1, 7'h3);
      idle;
      rd(2'h0, OFS_HDR, 32'h0201_0005);
      slot(11'h5, 6'h3, 3'h0, NL, NL, 7'h4, 7'h4);
      idle;
      rd(2'h0, OFS_HDR, 32'h0201_0005);
      rd(2'h0, OFS_STAT, 32'h0000_2121);
      slot(11'h5, 6'h4, 3'h0, VN, NO, 7'h8, 7'h0);
      rd(2'h0, OFS_HDR, 32'h0, 1'b1);
      idle;
      rd(2'h0, OFS_PAY + 10'h01c, 32'h0000_a007);
      wr(2'h1, OFS_CFG, 32'h0002_0807);
      wr(2'h1, OFS_CYC, 32'h0000_0204);
      wr(2'h1, OFS_CYC, 32'h0000_0003);
      rd(2'h1, OFS_CYC, 32'h0000_0204);
      slot(11'h7, 6'h5, 3'h0, VN, NO, 7'h5, 7'h0);
      idle;
      rd(2'h1, OFS_STAT, 32'h0);
      slot(11'h7, 6'h6, 3'h0, VN, NO, 7'h5, 7'h0);
      idle;
      rd(2'h1, OFS_HDR, 32'h0605_0007);
      rd(2'h1, OFS_PAY + 10'h004, 32'h0000_a001);
      slot(11'h7, 6'ha, 3'h3, VN, NO, 7'h1, 7'h0);
      idle;
      rd(2'h1, OFS_HDR, 32'h0605_0007);
      wr(2'h2, OFS_CFG, 32'h0001_1009);
      wr(2'h3, OFS_CFG, 32'h0001_1009);
      eng_b_flags <= 5'h18;
      slot(11'h9, 6'h0, 3'h4, NO, VN, 7'h0, 7'h1);
      idle;
      rd(2'h2, OFS_PAY, 32'h0000_b000);
      rd(2'h2, OFS_FLG, 32'h0155_00f8);
      rd(2'h3, OFS_HDR, 32'h0);
      // A two-channel buffer must not take a dynamic slot.
      slot(11'h5, 6'h0, 3'h4, VN, VN, 7'h1, 7'h1);
      idle;
      rd(2'h0, OFS_HDR, 32'h0408_0005);
      wrap_up();
   end
endmodule // tb_top

bind rxb_top rxb_props #(.MAX_WORDS(MAX_WORDS)) u_rxb_props (
   .sys_clk, .sys_rst, .reg_rd, .reg_rdata, .reg_rd_fail, .eng_slot_end,
   .eng_tx_claim_a, .eng_tx_claim_b, .eng_a_status, .eng_b_status,
   .pay_req, .pay_chan, .pay_idx, .rx_busy);
